/* rtl/mae_pkg.sv */
// package: register map, field positions and reset values of the mac engine
package mae_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] MAE_CFG_OFS   = 8'h00;
  localparam logic [7:0] MAE_FLAG_OFS  = 8'h04;
  localparam logic [7:0] MAE_OPA_OFS   = 8'h08;
  localparam logic [7:0] MAE_OPB_OFS   = 8'h0c;
  localparam logic [7:0] MAE_ACCL_OFS  = 8'h10;
  localparam logic [7:0] MAE_ACCH_OFS  = 8'h14;
  localparam logic [7:0] MAE_RND_OFS   = 8'h18;
  // ==========================================================================
  // configuration fields
  localparam int MAE_CFG_PROD_ONLY = 0;
  localparam int MAE_CFG_FRAC      = 1;
  localparam int MAE_CFG_SAT       = 2;
  localparam int MAE_CFG_CLR       = 3;
  localparam int MAE_CFG_SHDIR     = 4;
  localparam int MAE_CFG_SHIFT     = 5;
  // ==========================================================================
  // flag fields and reset values
  localparam int MAE_FLG_NEG  = 0;
  localparam int MAE_FLG_SOFT = 1;
  localparam int MAE_FLG_ZERO = 2;
  localparam int MAE_FLG_HARD = 3;
  localparam logic [5:0] MAE_CFG_RST  = 6'h00;
  localparam logic [3:0] MAE_FLAG_RST = 4'h4;
  localparam logic [39:0] MAE_ACC_RST = 40'h00_0000_0000;
  localparam logic [15:0] MAE_RND_RST = 16'h0000;
  localparam logic [15:0] MAE_RND_HALF = 16'h8000;
  localparam logic [15:0] MAE_SAT_POS  = 16'h7fff;
  localparam logic [15:0] MAE_SAT_NEG  = 16'h8000;
  localparam logic [1:0] MAE_RESP_OKAY   = 2'b00;
  localparam logic [1:0] MAE_RESP_SLVERR = 2'b10;
endpackage : mae_pkg

/* rtl/mae_engine.sv */
// file: multiply-accumulate engine with axi4-lite register slave
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module mae_engine
  import mae_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [5:0]  cfg;
    logic [3:0]  flags;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [39:0] acc;
    logic [15:0] rnd;
    logic        s1_valid;
    logic        s1_prod_only;
    logic        s1_clear;
    logic [39:0] s1_prod;
    logic        mul_go;
    logic        mul_prod_only;
    logic        mul_clear;
    logic        rnd_req;
  } mae_state_s;

  mae_state_s st;
  mae_state_s next_st;

  // ==========================================================================
  // rounding of accumulator bits 31..16, shared by the stage-2, shift and low-word write paths
  function automatic logic [15:0] mae_round(input logic [39:0] a,
                                            input logic        sat);
    logic        up;
    logic [16:0] sum;
    logic        pos_ovf;
    logic        neg_ovf;
    up = (a[15:0] > MAE_RND_HALF) ||
         ((a[15:0] == MAE_RND_HALF) && a[16]);
    sum = {a[31], a[31:16]} + {16'h0000, up};
    // overflow judged against the full 40-bit value, not only bits 31..16
    pos_ovf = !a[39] && ((|a[38:31]) || (sum[16] != sum[15]));
    neg_ovf = a[39] && !(&a[38:31]);
    if (sat && pos_ovf) begin
      mae_round = MAE_SAT_POS;
    end else if (sat && neg_ovf) begin
      mae_round = MAE_SAT_NEG;
    end else begin
      mae_round = sum[15:0];
    end
  endfunction : mae_round

  // ==========================================================================
  // combinational next state
  logic        wr_fire;
  logic        rd_fire;
  logic        start;
  logic        shift_now;
  logic [31:0] prod32;
  logic [39:0] prod40;
  logic [39:0] addend;
  logic [39:0] sum40;
  logic [39:0] shifted;
  logic [7:0]  wr_byte0;

  always_comb begin
    next_st  = st;
    wr_fire  = st.aw_held && st.w_held && !st.bvalid;
    rd_fire  = s_axi_arvalid && !st.rvalid;
    start    = 1'b0;
    wr_byte0 = st.w_data[7:0];
    prod32   = 32'(signed'(st.opa) * signed'(st.opb));
    prod40   = {{8{prod32[31]}}, prod32};
    if (st.cfg[MAE_CFG_FRAC]) begin
      prod40 = {prod40[38:0], 1'b0};
    end
    addend   = (st.s1_prod_only || st.s1_clear) ? MAE_ACC_RST
                                                : st.acc;
    sum40    = addend + st.s1_prod;
    shift_now = st.cfg[MAE_CFG_SHIFT];
    shifted  = st.cfg[MAE_CFG_SHDIR] ? {st.acc[39], st.acc[39:1]}
                                     : {st.acc[38:0], 1'b0};

    // ------------------------------------------------------------ bus accept
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // ------------------------------------------------------------ pipeline
    // stage 3: rounding of the value stored by stage 2 or by a shift/write
    next_st.rnd_req = 1'b0;
    if (st.rnd_req) begin
      next_st.rnd = mae_round(st.acc, st.cfg[MAE_CFG_SAT]);
    end
    // stage 2: add and store, with the flags set from the sum in the same cycle
    if (st.s1_valid) begin
      next_st.acc = sum40;
      next_st.rnd_req = 1'b1;
      next_st.flags[MAE_FLG_ZERO] = (sum40 == MAE_ACC_RST);
      next_st.flags[MAE_FLG_NEG]  = sum40[39];
      next_st.flags[MAE_FLG_SOFT] = (sum40[39:31] != {9{sum40[39]}});
      if (st.s1_clear) begin
        next_st.flags[MAE_FLG_HARD] = 1'b0;
      end
      if (!st.s1_prod_only &&
          (((addend[39:32] == 8'h7f) && (sum40[39:32] == 8'h80)) ||
           ((addend[39:32] == 8'h80) && (sum40[39:32] == 8'h7f)))) begin
        next_st.flags[MAE_FLG_HARD] = 1'b1;
      end
    end else if (shift_now) begin
      next_st.acc = shifted;
      next_st.rnd_req = 1'b1;
      next_st.cfg[MAE_CFG_SHIFT] = 1'b0;
    end
    next_st.s1_valid = 1'b0;
    // stage 1: multiply the operands left behind by the start write
    if (st.mul_go) begin
      next_st.s1_valid     = 1'b1;
      next_st.s1_prod      = prod40;
      next_st.s1_prod_only = st.mul_prod_only;
      next_st.s1_clear     = st.mul_clear;
    end
    next_st.mul_go = 1'b0;

    // ------------------------------------------------------------ register write
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = MAE_RESP_OKAY;
      case (st.aw_addr)
        MAE_CFG_OFS: begin
          if (st.w_strb[0]) begin
            next_st.cfg = wr_byte0[5:0];
          end
        end
        MAE_FLAG_OFS: begin
          if (st.w_strb[0] && !st.s1_valid) begin
            next_st.flags = wr_byte0[3:0];
          end
        end
        MAE_OPA_OFS: begin
          if (st.w_strb[0]) next_st.opa[7:0]  = st.w_data[7:0];
          if (st.w_strb[1]) next_st.opa[15:8] = st.w_data[15:8];
        end
        MAE_OPB_OFS: begin
          if (st.w_strb[1]) next_st.opb[15:8] = st.w_data[15:8];
          if (st.w_strb[0]) begin
            next_st.opb[7:0] = st.w_data[7:0];
            start = 1'b1;
          end
        end
        MAE_ACCL_OFS: begin
          if (!st.s1_valid) begin
            for (int i = 0; i < 4; i++) begin
              if (st.w_strb[i]) next_st.acc[i*8 +: 8] = st.w_data[i*8 +: 8];
            end
            if (st.w_strb[0]) next_st.rnd_req = 1'b1;
          end
        end
        MAE_ACCH_OFS: begin
          if (st.w_strb[0] && !st.s1_valid) begin
            next_st.acc[39:32] = wr_byte0;
          end
        end
        MAE_RND_OFS: begin
          next_st.bresp = MAE_RESP_OKAY;
        end
        default: begin
          next_st.bresp = MAE_RESP_SLVERR;
        end
      endcase
    end

    // start: operands settle at this edge, so the multiply runs next cycle
    if (start) begin
      next_st.mul_go        = 1'b1;
      next_st.mul_prod_only = st.cfg[MAE_CFG_PROD_ONLY];
      next_st.mul_clear     = st.cfg[MAE_CFG_CLR];
      next_st.cfg[MAE_CFG_CLR] = 1'b0;
    end

    // ------------------------------------------------------------ register read
    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = MAE_RESP_OKAY;
      case (s_axi_araddr)
        MAE_CFG_OFS:  next_st.rdata = {26'h0, st.cfg};
        MAE_FLAG_OFS: next_st.rdata = {28'h0, st.flags};
        MAE_OPA_OFS:  next_st.rdata = {16'h0, st.opa};
        MAE_OPB_OFS:  next_st.rdata = {16'h0, st.opb};
        MAE_ACCL_OFS: next_st.rdata = st.acc[31:0];
        MAE_ACCH_OFS: next_st.rdata = {24'h0, st.acc[39:32]};
        MAE_RND_OFS:  next_st.rdata = {16'h0, st.rnd};
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = MAE_RESP_SLVERR;
        end
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st.aw_held      <= 1'b0;
      st.aw_addr      <= 8'h00;
      st.w_held       <= 1'b0;
      st.w_data       <= 32'h0000_0000;
      st.w_strb       <= 4'h0;
      st.bvalid       <= 1'b0;
      st.bresp        <= MAE_RESP_OKAY;
      st.rvalid       <= 1'b0;
      st.rresp        <= MAE_RESP_OKAY;
      st.rdata        <= 32'h0000_0000;
      st.cfg          <= MAE_CFG_RST;
      st.flags        <= MAE_FLAG_RST;
      st.opa          <= 16'h0000;
      st.opb          <= 16'h0000;
      st.acc          <= MAE_ACC_RST;
      st.rnd          <= MAE_RND_RST;
      st.s1_valid     <= 1'b0;
      st.s1_prod_only <= 1'b0;
      st.s1_clear     <= 1'b0;
      st.s1_prod      <= MAE_ACC_RST;
      st.mul_go        <= 1'b0;
      st.mul_prod_only <= 1'b0;
      st.mul_clear     <= 1'b0;
      st.rnd_req      <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // bus outputs
  assign s_axi_awready = !st.aw_held;
  assign s_axi_wready  = !st.w_held;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

endmodule : mae_engine

/* sim/mae_engine_checker.sv */
// checker: bus timing and read-back widths of the mac engine
`timescale 1ns/10ps
module mae_engine_checker
  import mae_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write side
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read side
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire w_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire r_go = s_axi_arvalid && s_axi_arready;
  // ======
  // answers
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_lat: assert property (r_go |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_lat: assert property (w_go |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_bad_read: assert property (r_go && s_axi_araddr > 8'h18
    |=> s_axi_rresp == MAE_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read");
  a_bad_write: assert property (w_go && s_axi_awaddr > 8'h18
    |-> ##2 s_axi_bresp == MAE_RESP_SLVERR) else $error("unmapped write");
  a_flag_width: assert property (r_go && s_axi_araddr == MAE_FLAG_OFS
    |=> s_axi_rdata[31:4] == 28'h0) else $error("flag bits wide");
  a_top_width: assert property (r_go && s_axi_araddr == MAE_ACCH_OFS
    |=> s_axi_rdata[31:8] == 24'h0) else $error("top byte wide");
endmodule : mae_engine_checker

bind mae_engine mae_engine_checker u_mae_engine_checker (.*);

/* sim/mae_host.sv */
// host model: axi4-lite master standing in for the processor core
`timescale 1ns/10ps
module mae_host (
  // clock
  input  wire logic        aclk,
  // write
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // read
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
  end
  // ======
  // one word write; valids drop only where taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    if (!s_axi_bvalid) tb_multiply_accumulate_engine.hang();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // ======
  // one word read
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    if (!s_axi_rvalid) tb_multiply_accumulate_engine.hang();
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : mae_host

/* sim/tb_multiply_accumulate_engine.sv */
// testbench: register-level checks of the multiply-accumulate engine
`timescale 1ns/10ps
module tb_multiply_accumulate_engine
  import mae_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          err_count = 0;
  int          num_checks = 0;
  // cfg, top byte, low word, expected rounding
  logic [31:0] tv [7][4] = '{'{0, 0, 32'h0001_8000, 32'h2},
    '{0, 0, 32'h0002_8000, 32'h2}, '{0, 0, 32'h0002_8001, 32'h3},
    '{0, 0, 32'h7fff_8000, 32'h8000}, '{4, 0, 32'h7fff_8000, 32'h7fff},
    '{4, 32'hff, 0, 32'h8000}, '{2, 0, 32'h0001_8000, 32'h2}};
  mae_engine u_mae_engine (.*);
  mae_host u_mae_host (.*);
  always #25 aclk = ~aclk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic w(logic [7:0] a, logic [31:0] v);
    u_mae_host.wr(a, v, r);
    chk("bresp", MAE_RESP_OKAY, r);
  endtask : w
  task automatic rc(string nm, logic [7:0] a, logic [31:0] e,
                    logic [31:0] m = 32'hffff_ffff);
    u_mae_host.rd(a, d, r);
    chk("rresp", MAE_RESP_OKAY, r);
    chk(nm, e, d & m);
  endtask : rc
  // start an operation, then give the pipeline its three cycles
  task automatic st(logic [31:0] b);
    w(MAE_OPB_OFS, b);
    repeat (3) @(posedge aclk);
  endtask : st
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic hang();
    err_count++;
    give_verdict();
  endtask : hang
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc("cfg", MAE_CFG_OFS, 0);
    rc("flags", MAE_FLAG_OFS, 32'h4);
    rc("acc", MAE_ACCL_OFS, 0);
    rc("rnd", MAE_RND_OFS, 0);
    // ======
    // fractional accumulate, clear at start
    w(MAE_CFG_OFS, 32'ha);
    w(MAE_OPA_OFS, 32'h4000);
    st(32'h2000);
    rc("acc", MAE_ACCL_OFS, 32'h1000_0000);
    rc("cfg", MAE_CFG_OFS, 32'h2);
    st(32'he000);
    rc("acc", MAE_ACCL_OFS, 0);
    rc("flags", MAE_FLAG_OFS, 32'h4);
    // ======
    // product only over old contents, hard flag kept
    w(MAE_FLAG_OFS, 32'h8);
    w(MAE_ACCL_OFS, 32'h1234);
    w(MAE_CFG_OFS, 32'h1);
    w(MAE_OPA_OFS, 32'h1234);
    st(32'hfedc);
    rc("acc", MAE_ACCL_OFS, 32'hffeb_3cb0);
    rc("acch", MAE_ACCH_OFS, 32'hff);
    rc("flags", MAE_FLAG_OFS, 32'h9);
    rc("rnd", MAE_RND_OFS, 32'hffeb);
    // ======
    // accumulate across the top byte boundary
    w(MAE_FLAG_OFS, 0);
    w(MAE_CFG_OFS, 0);
    w(MAE_ACCH_OFS, 32'h7f);
    w(MAE_ACCL_OFS, 32'hffff_ffff);
    w(MAE_OPA_OFS, 32'h1);
    st(32'h1);
    rc("acch", MAE_ACCH_OFS, 32'h80);
    rc("flags", MAE_FLAG_OFS, 32'hb);
    // clear at start drops the hard flag and the old contents
    w(MAE_CFG_OFS, 32'h8);
    st(32'h1);
    rc("acc", MAE_ACCL_OFS, 32'h1);
    rc("flags", MAE_FLAG_OFS, 0);
    rc("cfg", MAE_CFG_OFS, 0);
    // ======
    // shifts: left once, right twice, flags untouched
    w(MAE_FLAG_OFS, 32'ha);
    w(MAE_ACCH_OFS, 32'h40);
    w(MAE_ACCL_OFS, 32'h8844_2211);
    w(MAE_CFG_OFS, 32'h20);
    rc("acc", MAE_ACCL_OFS, 32'h1088_4422);
    rc("acch", MAE_ACCH_OFS, 32'h81);
    rc("rnd", MAE_RND_OFS, 32'h1088);
    rc("cfg", MAE_CFG_OFS, 0);
    w(MAE_CFG_OFS, 32'h30);
    w(MAE_CFG_OFS, 32'h30);
    rc("acc", MAE_ACCL_OFS, 32'h4422_1108);
    rc("acch", MAE_ACCH_OFS, 32'he0);
    rc("rnd", MAE_RND_OFS, 32'h4422);
    rc("flags", MAE_FLAG_OFS, 32'ha);
    // ======
    // rounding ties, saturation, both modes
    for (int i = 0; i < 7; i++) begin
      w(MAE_CFG_OFS, tv[i][0]);
      w(MAE_ACCH_OFS, tv[i][1]);
      w(MAE_ACCL_OFS, tv[i][2]);
      rc("rnd", MAE_RND_OFS, tv[i][3]);
      rc("acc", MAE_ACCL_OFS, tv[i][2]);
    end
    // ======
    // unmapped offset
    u_mae_host.rd(8'h1c, d, r);
    chk("rresp", MAE_RESP_SLVERR, r);
    u_mae_host.wr(8'h1c, 32'h1, r);
    chk("bresp", MAE_RESP_SLVERR, r);
    give_verdict();
  end
endmodule : tb_multiply_accumulate_engine
